/* File: eac_pkg.sv */
// Purpose: Shared constants and types for the nonvolatile access control block.
// Assumes: 100 MHz system clock; I/O space register addresses as seen by IN/OUT.
// Notes:   Timing figures are kept in their own units; the divider and split cycle count derive from them, the atomic count is given directly.
`default_nettype none
package eac_pkg;

    // ***********************************************************************
    // Register map and fields
    // ***********************************************************************
    localparam logic [5:0] EAC_CTRL_ADDR    = 6'h1f;
    localparam logic [5:0] EAC_DATA_ADDR    = 6'h20;
    localparam logic [5:0] EAC_ADDR_LO_ADDR = 6'h21;
    localparam logic [5:0] EAC_ADDR_HI_ADDR = 6'h22;

    localparam int EAC_READ_STROBE_BIT   = 0;
    localparam int EAC_PROGRAM_STROBE_BIT = 1;
    localparam int EAC_MASTER_WE_BIT     = 2;
    localparam int EAC_READY_IRQ_EN_BIT  = 3;
    localparam int EAC_MODE_LO_BIT       = 4;
    localparam int EAC_MODE_HI_BIT       = 5;

    localparam int EAC_ADDR_W = 12;
    localparam int EAC_DATA_W = 8;

    localparam logic [1:0]  EAC_MODE_RESET  = 2'h0;
    localparam logic [11:0] EAC_ADDR_RESET  = 12'h000;
    localparam logic [7:0]  EAC_DATA_RESET  = 8'h00;
    localparam logic [7:0]  EAC_ERASED_BYTE = 8'hff;

    // ***********************************************************************
    // Timing
    // ***********************************************************************
    localparam int EAC_CLK_FREQ_KHZ      = 100000;
    localparam int EAC_RC_FREQ_KHZ       = 8000;
    localparam int EAC_RC_DIV            = EAC_CLK_FREQ_KHZ / EAC_RC_FREQ_KHZ;
    localparam int EAC_ATOMIC_RC_CYCLES  = 26368;
    localparam int EAC_SPLIT_TIME_US     = 1800;
    localparam int EAC_SPLIT_RC_CYCLES   = EAC_SPLIT_TIME_US * EAC_RC_FREQ_KHZ / 1000;
    localparam logic [2:0] EAC_MWE_WINDOW   = 3'h4;
    localparam logic [2:0] EAC_WRITE_STALL  = 3'h2;
    localparam logic [2:0] EAC_READ_STALL   = 3'h4;

    // ***********************************************************************
    // Types
    // ***********************************************************************
    typedef enum logic [1:0] {
        EAC_OP_ATOMIC,
        EAC_OP_ERASE,
        EAC_OP_WRITE,
        EAC_OP_RESERVED
    } eac_op_e;

    typedef struct packed {
        logic [5:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } eac_io_req_s;

endpackage
`default_nettype wire

/* File: eac_array.sv */
// Purpose: Byte-wide nonvolatile array model with a registered read port.
// Assumes: One access per cycle; write and read never issued together.
// Notes:   Erase sets a byte to all ones; write-only can only clear bits.
`timescale 1ns/100ps
`default_nettype none
module eac_array
    import eac_pkg::*;
#(
    parameter int AW = EAC_ADDR_W,
    parameter int DW = EAC_DATA_W
) (
    input  wire logic          clk,
    input  wire logic          rd_en,
    input  wire logic          wr_en,
    input  wire eac_op_e       op,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            unique case (op)
                EAC_OP_ATOMIC: mem[addr] <= wdata;
                EAC_OP_ERASE:  mem[addr] <= EAC_ERASED_BYTE;
                EAC_OP_WRITE:  mem[addr] <= mem[addr] & wdata;
                default:       mem[addr] <= mem[addr];
            endcase
        end
        if (rd_en) begin
            rdata <= mem[addr];
        end
    end

endmodule
`default_nettype wire

/* File: eac_ctrl.sv */
// Purpose: Nonvolatile access control: control, address and data registers in I/O space.
// Assumes: Core issues one I/O access per cycle; global enable and self-program flag on clk.
// Notes:   A write in progress survives reset and runs to completion.
//
// Functional notes
// - Ready interrupt when enabled and global enable set.
// - Ready interrupt is a level while idle.
// - Strobe within four cycles of arming programs byte.
// - Strobe without master enable does nothing.
// - Master enable self-clears after four cycles.
// - No array write while flash self-programs.
// - Hardware clears program strobe when time elapses.
// - Program strobe stalls core two cycles.
// - Read strobe loads data register two cycles later.
// - Read strobe stalls core four cycles.
// - Busy write refuses reads and address changes.
// - Atomic write timed as 26368 oscillator cycles.
// - Mode bits select erase, write or both.
// - Mode bits frozen while busy; reset clears them when idle.
// - Twelve-bit address; upper four bits read zero.
`timescale 1ns/100ps
`default_nettype none
module eac_ctrl
    import eac_pkg::*;
#(
    parameter int ATOMIC_CYCLES = EAC_ATOMIC_RC_CYCLES,
    parameter int SPLIT_CYCLES  = EAC_SPLIT_RC_CYCLES,
    parameter int RC_DIV        = EAC_RC_DIV
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire eac_io_req_s io_req,
    input  wire logic        global_irq_enable,
    input  wire logic        self_program_active,
    output logic      [7:0]  io_rdata,
    output logic             ready_irq,
    output logic             cpu_stall
);

    // ***********************************************************************
    // State
    // ***********************************************************************
    logic [EAC_ADDR_W-1:0] addr_r,     addr_nxt;
    logic [EAC_DATA_W-1:0] data_r,     data_nxt;
    logic [1:0]            mode_r,     mode_nxt;
    logic                  rie_r,      rie_nxt;
    logic                  mwe_r,      mwe_nxt;
    logic [2:0]            mwe_cnt_r,  mwe_cnt_nxt;
    logic                  busy_r,     busy_nxt;
    logic [14:0]           wcnt_r,     wcnt_nxt;
    logic [3:0]            div_r,      div_nxt;
    logic                  tick_r,     tick_nxt;
    logic                  rd_pend_r,  rd_pend_nxt;
    logic [2:0]            stall_cnt_r, stall_cnt_nxt;
    logic                  stall_r,    stall_nxt;
    logic                  irq_r,      irq_nxt;
    logic [7:0]            rdata_r,    rdata_nxt;

    logic                  ctrl_wr;
    logic                  start_wr;
    logic                  start_rd;
    logic [1:0]            mode_eff;
    logic [EAC_DATA_W-1:0] mem_rdata;
    logic [7:0]            ctrl_view;

    // Converts a cycle count parameter to the width of the write timer.
    function automatic logic [14:0] cyc15(input int n);
        cyc15 = n[14:0];
    endfunction

    // ***********************************************************************
    // Next-state logic
    // ***********************************************************************
    always_comb begin
        addr_nxt      = addr_r;
        data_nxt      = data_r;
        mode_nxt      = mode_r;
        rie_nxt       = rie_r;
        mwe_nxt       = mwe_r;
        mwe_cnt_nxt   = mwe_cnt_r;
        busy_nxt      = busy_r;
        wcnt_nxt      = wcnt_r;
        rd_pend_nxt   = 1'b0;
        stall_cnt_nxt = stall_cnt_r;
        rdata_nxt     = rdata_r;

        ctrl_wr  = io_req.wr && (io_req.addr == EAC_CTRL_ADDR);
        mode_eff = busy_r ? mode_r : io_req.wdata[EAC_MODE_HI_BIT:EAC_MODE_LO_BIT];
        // Only a strobe inside the armed window, with no flash self-programming, launches.
        start_wr = ctrl_wr && io_req.wdata[EAC_PROGRAM_STROBE_BIT] && mwe_r && !busy_r
                   && !self_program_active
                   && (mode_eff != EAC_OP_RESERVED);
        start_rd = ctrl_wr && io_req.wdata[EAC_READ_STROBE_BIT] && !busy_r && !start_wr;

        // The oscillator-rate enable used to time array writes.
        if (div_r == 4'(RC_DIV - 1)) begin
            div_nxt  = 4'h0;
            tick_nxt = 1'b1;
        end else begin
            div_nxt  = div_r + 4'h1;
            tick_nxt = 1'b0;
        end

        // Master enable window; re-arming needs the bit to have expired first.
        if (mwe_cnt_r != 3'h0) begin
            mwe_cnt_nxt = mwe_cnt_r - 3'h1;
        end
        if (ctrl_wr && io_req.wdata[EAC_MASTER_WE_BIT] && !mwe_r) begin
            mwe_cnt_nxt = EAC_MWE_WINDOW;
        end
        if (start_wr) begin
            mwe_cnt_nxt = 3'h0;
        end
        mwe_nxt = (mwe_cnt_nxt != 3'h0);

        if (ctrl_wr) begin
            rie_nxt = io_req.wdata[EAC_READY_IRQ_EN_BIT];
            if (!busy_r) begin
                mode_nxt = mode_eff;
            end
        end

        if (io_req.wr && !busy_r) begin
            if (io_req.addr == EAC_ADDR_LO_ADDR) begin
                addr_nxt[7:0] = io_req.wdata;
            end
            if (io_req.addr == EAC_ADDR_HI_ADDR) begin
                addr_nxt[EAC_ADDR_W-1:8] = io_req.wdata[EAC_ADDR_W-9:0];
            end
        end
        if (io_req.wr && (io_req.addr == EAC_DATA_ADDR)) begin
            data_nxt = io_req.wdata;
        end

        // Write timer runs on the oscillator enable; hardware alone clears the strobe.
        if (start_wr) begin
            busy_nxt = 1'b1;
            wcnt_nxt = (mode_eff == EAC_OP_ATOMIC) ? cyc15(ATOMIC_CYCLES)
                                                   : cyc15(SPLIT_CYCLES);
        end else if (busy_r && tick_r) begin
            wcnt_nxt = wcnt_r - 15'h1;
            if (wcnt_r == 15'h1) begin
                busy_nxt = 1'b0;
            end
        end

        // Read: array answers next cycle, then the data register takes the byte.
        if (start_rd) begin
            rd_pend_nxt = 1'b1;
        end
        if (rd_pend_r) begin
            data_nxt = mem_rdata;
        end

        if (stall_cnt_r != 3'h0) begin
            stall_cnt_nxt = stall_cnt_r - 3'h1;
        end
        if (start_wr) begin
            stall_cnt_nxt = EAC_WRITE_STALL;
        end else if (start_rd) begin
            stall_cnt_nxt = EAC_READ_STALL;
        end
        stall_nxt = (stall_cnt_nxt != 3'h0);

        irq_nxt = rie_nxt && global_irq_enable && !busy_nxt;

        ctrl_view = {2'b00, mode_r, rie_r, mwe_r, busy_r, rd_pend_r};
        if (io_req.rd) begin
            unique case (io_req.addr)
                EAC_CTRL_ADDR:    rdata_nxt = ctrl_view;
                EAC_DATA_ADDR:    rdata_nxt = data_r;
                EAC_ADDR_LO_ADDR: rdata_nxt = addr_r[7:0];
                EAC_ADDR_HI_ADDR: rdata_nxt = {4'h0, addr_r[EAC_ADDR_W-1:8]};
                default:          rdata_nxt = 8'h00;
            endcase
        end

        // Reset lets a running array write finish with its mode intact.
        if (rst) begin
            addr_nxt      = EAC_ADDR_RESET;
            data_nxt      = EAC_DATA_RESET;
            rie_nxt       = 1'b0;
            mwe_nxt       = 1'b0;
            mwe_cnt_nxt   = 3'h0;
            rd_pend_nxt   = 1'b0;
            stall_cnt_nxt = 3'h0;
            stall_nxt     = 1'b0;
            irq_nxt       = 1'b0;
            rdata_nxt     = 8'h00;
            // A running write keeps its mode; an unknown flag at start-up takes the clearing branch.
            if (busy_r) begin
                mode_nxt = mode_r;
            end else begin
                mode_nxt = EAC_MODE_RESET;
                busy_nxt = 1'b0;
                wcnt_nxt = 15'h0;
                div_nxt  = 4'h0;
                tick_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        addr_r      <= addr_nxt;
        data_r      <= data_nxt;
        mode_r      <= mode_nxt;
        rie_r       <= rie_nxt;
        mwe_r       <= mwe_nxt;
        mwe_cnt_r   <= mwe_cnt_nxt;
        busy_r      <= busy_nxt;
        wcnt_r      <= wcnt_nxt;
        div_r       <= div_nxt;
        tick_r      <= tick_nxt;
        rd_pend_r   <= rd_pend_nxt;
        stall_cnt_r <= stall_cnt_nxt;
        stall_r     <= stall_nxt;
        irq_r       <= irq_nxt;
        rdata_r     <= rdata_nxt;
    end

    assign io_rdata  = rdata_r;
    assign ready_irq = irq_r;
    assign cpu_stall = stall_r;

    // ***********************************************************************
    // Array
    // ***********************************************************************
    eac_array #(
        .AW (EAC_ADDR_W),
        .DW (EAC_DATA_W)
    ) u_array (
        .clk   (clk),
        .rd_en (start_rd && !rst),
        .wr_en (start_wr && !rst),
        .op    (eac_op_e'(mode_eff)),
        .addr  (addr_r),
        .wdata (data_r),
        .rdata (mem_rdata)
    );

    // ***********************************************************************
    // Assertions
    // ***********************************************************************
    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        ##1 (ready_irq == (rie_r && !busy_r && $past(global_irq_enable))))
        else $error("ready interrupt does not follow enable and idle state");

    a_irq_while_busy: assert property (@(posedge clk) disable iff (rst)
        busy_r |-> !ready_irq)
        else $error("ready interrupt raised while a write is running");

    a_mwe_expires: assert property (@(posedge clk) disable iff (rst)
        $rose(mwe_r) |-> ##[1:4] !mwe_r)
        else $error("master write enable outlived its window");

    a_write_gated: assert property (@(posedge clk) disable iff (rst)
        start_wr |-> (mwe_r && !busy_r && !self_program_active))
        else $error("array write started without arming or during self-programming");

    a_write_stall: assert property (@(posedge clk) disable iff (rst)
        start_wr |=> cpu_stall [*2] ##1 !cpu_stall)
        else $error("write stall is not two cycles");

    a_read_stall: assert property (@(posedge clk) disable iff (rst)
        start_rd |=> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall is not four cycles");

    a_read_data: assert property (@(posedge clk) disable iff (rst)
        start_rd |=> ##1 (data_r == $past(mem_rdata) && !rd_pend_r))
        else $error("read data not loaded or read strobe not cleared");

    a_addr_frozen: assert property (@(posedge clk) disable iff (rst)
        (busy_r && io_req.wr) |=> (addr_r == $past(addr_r)))
        else $error("address changed while a write was running");

    a_busy_ends: assert property (@(posedge clk) disable iff (rst)
        (busy_r && tick_r && wcnt_r == 15'h1) |=> !busy_r)
        else $error("program strobe not cleared when the write time elapsed");

    a_mode_frozen: assert property (@(posedge clk) disable iff (rst)
        busy_r |=> (mode_r == $past(mode_r)))
        else $error("mode bits changed while a write was running");

    a_strobe_armed: assert property (@(posedge clk) disable iff (rst)
        $rose(busy_r) |-> ($past(mwe_r) && !$past(self_program_active)))
        else $error("write began without master enable or during self-programming");

    a_write_starts: assert property (@(posedge clk) disable iff (rst)
        (io_req.wr && io_req.addr == EAC_CTRL_ADDR && io_req.wdata[EAC_PROGRAM_STROBE_BIT] && mwe_r && !busy_r
         && !self_program_active && io_req.wdata[EAC_MODE_HI_BIT:EAC_MODE_LO_BIT] != EAC_OP_RESERVED)
        |=> (busy_r && !mwe_r))
        else $error("strobe inside the armed window did not start a write");

    a_addr_hi_zero: assert property (@(posedge clk) disable iff (rst)
        (io_req.rd && io_req.addr == EAC_ADDR_HI_ADDR) |=> (io_rdata[7:4] == 4'h0))
        else $error("reserved address bits did not read zero");

    a_read_refused: assert property (@(posedge clk) disable iff (rst)
        busy_r |=> !rd_pend_r)
        else $error("read started while a write was running");

endmodule
`default_nettype wire

/* File: eac_ctrl_bench.sv */
// Purpose: Self-checking bench for the nonvolatile access control block.
// Assumes: Write timing is shortened through the block parameters.
// Notes:   Array contents are tracked only for bytes the bench has written.
`timescale 1ns/100ps
`default_nettype none
module eac_ctrl_bench
    import eac_pkg::*;
;
    localparam int AT = 20;
    localparam int SP = 10;
    localparam int DV = 2;

    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    eac_io_req_s req       = '0;
    logic        gie       = 1'b0;
    logic        spa       = 1'b0;
    logic        ie        = 1'b0;
    logic  [7:0] rdata;
    logic        irq;
    logic        stall;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc       = 0;
    logic  [7:0] mem [int];
    logic [11:0] ra [4];

    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    eac_ctrl #(.ATOMIC_CYCLES(AT), .SPLIT_CYCLES(SP), .RC_DIV(DV)) u_eac_ctrl (
        .clk(clk), .rst(rst), .io_req(req), .global_irq_enable(gie), .self_program_active(spa),
        .io_rdata(rdata), .ready_irq(irq), .cpu_stall(stall));

    // ****************************
    // Tasks
    // ****************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One register access; read data is settled when the task returns.
    task automatic acc(int n, logic [5:0] a, logic w, logic [7:0] d);
        repeat (n) @(posedge clk);
        #1;
        req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask

    task automatic rdchk(logic [5:0] a, logic [7:0] exp, string name);
        acc(1, a, 1'b0, 8'h00);
        chk(name, rdata, exp);
    endtask

    task automatic stall_chk(int n);
        for (int i = 0; i <= n; i++) begin
            chk("cpu_stall", {7'h0, stall}, {7'h0, i < n});
            @(posedge clk);
            #1;
        end
    endtask

    task automatic irq_chk(logic e);
        repeat (2) @(posedge clk);
        #1;
        chk("ready_irq", {7'h0, irq}, {7'h0, e});
    endtask

    task automatic rst_pulse();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
    endtask

    task automatic wait_idle(int t0, int n);
        for (int i = 0; i < 200; i++) begin
            acc(1, EAC_CTRL_ADDR, 1'b0, 8'h00);
            if (rdata[1] === 1'b0) begin
                chk("write_time", {7'h0, (cyc - t0) >= n - 2 && (cyc - t0) <= n + 6}, 8'h01);
                return;
            end
        end
        bad_count++;
        $display("ERROR program_strobe expected 0 seen 1");
        summarize();
    endtask

    task automatic do_write(logic [11:0] a, logic [7:0] d, logic [1:0] m, int gap, logic arm, logic ok, int mid);
        int         t0;
        logic [7:0] c;
        c = {2'b00, m, ie, 3'b000};
        acc(1, EAC_ADDR_LO_ADDR, 1'b1, a[7:0]);
        acc(1, EAC_ADDR_HI_ADDR, 1'b1, {4'h0, a[11:8]});
        acc(1, EAC_DATA_ADDR, 1'b1, d);
        if (arm) acc(1, EAC_CTRL_ADDR, 1'b1, c | 8'h04);
        acc(gap, EAC_CTRL_ADDR, 1'b1, c | 8'h02);
        t0 = cyc;
        if (!ok) begin
            stall_chk(0);
            acc(4, EAC_CTRL_ADDR, 1'b0, 8'h00);
            chk("ctrl_refused", rdata, c);
            return;
        end
        stall_chk(2);
        chk("irq_busy", {7'h0, irq}, 8'h00);
        if (mid == 1) begin
            acc(1, EAC_ADDR_LO_ADDR, 1'b1, ~a[7:0]);
            acc(1, EAC_CTRL_ADDR, 1'b1, {2'b00, 2'b11, ie, 3'b011});
            stall_chk(0);
            rdchk(EAC_CTRL_ADDR, c | 8'h02, "ctrl_busy");
        end
        if (mid == 2) begin
            rst_pulse();
            rdchk(EAC_CTRL_ADDR, {2'b00, m, 4'b0010}, "ctrl_busy_rst");
        end
        wait_idle(t0, m == 2'b00 ? AT * DV : SP * DV);
        case (m)
            2'b00: mem[a] = d;
            2'b01: mem[a] = 8'hff;
            default: mem[a] = mem[a] & d;
        endcase
        irq_chk(ie & gie);
    endtask

    task automatic rd_byte(logic [11:0] a, logic setaddr);
        if (setaddr) begin
            acc(1, EAC_ADDR_LO_ADDR, 1'b1, a[7:0]);
            acc(1, EAC_ADDR_HI_ADDR, 1'b1, {4'h0, a[11:8]});
        end
        acc(1, EAC_CTRL_ADDR, 1'b1, {4'h0, ie, 3'b001});
        stall_chk(4);
        rdchk(EAC_CTRL_ADDR, {4'h0, ie, 3'b000}, "read_strobe");
        rdchk(EAC_DATA_ADDR, mem[a], "data_reg");
    endtask

    // ****************************
    // Sequence
    // ****************************
    initial begin
        void'($urandom(32'h2015));
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        rdchk(EAC_CTRL_ADDR, 8'h00, "ctrl_reset");
        acc(1, EAC_ADDR_HI_ADDR, 1'b1, 8'hff);
        rdchk(EAC_ADDR_HI_ADDR, 8'h0f, "addr_hi");
        acc(1, EAC_CTRL_ADDR, 1'b1, 8'he0);
        rst_pulse();
        rdchk(EAC_CTRL_ADDR, 8'h00, "mode_reset");
        acc(1, 6'h23, 1'b1, 8'h5a);
        rdchk(6'h23, 8'h00, "unmapped");
        acc(1, EAC_CTRL_ADDR, 1'b1, 8'h04);
        rdchk(EAC_CTRL_ADDR, 8'h04, "mwe_armed");
        acc(1, EAC_CTRL_ADDR, 1'b0, 8'h00);
        chk("mwe_c4", rdata, 8'h04);
        acc(0, EAC_CTRL_ADDR, 1'b0, 8'h00);
        chk("mwe_expired", rdata, 8'h00);
        acc(1, EAC_CTRL_ADDR, 1'b1, 8'h08);
        irq_chk(1'b0);
        gie = 1'b1;
        irq_chk(1'b1);
        irq_chk(1'b1);
        acc(1, EAC_CTRL_ADDR, 1'b1, 8'h00);
        irq_chk(1'b0);
        ie = 1'b1;
        do_write(12'h123, 8'h3c, 2'b00, 1, 1'b1, 1'b1, 0);
        do_write(12'h123, 8'h11, 2'b00, 1, 1'b0, 1'b0, 0);
        do_write(12'h123, 8'h22, 2'b00, 4, 1'b1, 1'b0, 0);
        do_write(12'h123, 8'h33, 2'b11, 1, 1'b1, 1'b0, 0);
        spa = 1'b1;
        do_write(12'h123, 8'h44, 2'b00, 1, 1'b1, 1'b0, 0);
        spa = 1'b0;
        rd_byte(12'h123, 1'b1);
        do_write(12'hfed, 8'h00, 2'b01, 3, 1'b1, 1'b1, 0);
        do_write(12'hfed, 8'ha5, 2'b10, 2, 1'b1, 1'b1, 0);
        do_write(12'hfed, 8'h3c, 2'b10, 1, 1'b1, 1'b1, 1);
        rd_byte(12'hfed, 1'b0);
        ie = 1'b0;
        do_write(12'h0a0, 8'h96, 2'b01, 1, 1'b1, 1'b1, 2);
        rd_byte(12'h0a0, 1'b1);
        ie = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ra[i] = 12'($urandom);
            do_write(ra[i], 8'($urandom), 2'b00, 1 + i % 3, 1'b1, 1'b1, 0);
        end
        for (int i = 0; i < 4; i++) rd_byte(ra[i], 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
